// ### core/sci_flags.sv
// module: status flags, ninth bits, error enables and data buffer of the serial interface
`timescale 1ns/1ps
`default_nettype none
module sci_flags
    import sci_flags_pkg::*;
(
    input  wire logic        clk_sys,          // 40 MHz bus clock
    input  wire logic        nrst,             // async reset, active low
    input  wire logic        clk_en,           // freezes all state when low
    input  wire logic [7:0]  address,          // avalon byte address
    input  wire logic        read,             // avalon read
    input  wire logic        write,            // avalon write
    input  wire logic [31:0] writedata,        // avalon write data
    input  wire logic [3:0]  byteenable,       // avalon byte enables
    output logic      [31:0] readdata,         // avalon read data
    output logic             waitrequest,      // avalon wait
    input  wire logic        char_len_sel,     // 1 = 9-bit characters
    input  wire logic        tx_empty_irq_en,  // holding-empty interrupt enable
    input  wire logic        tx_done_irq_en,   // completion interrupt enable
    input  wire logic        rx_full_irq_en,   // receive interrupt enable
    input  wire logic        idle_irq_en,      // idle interrupt enable
    input  wire logic        rx_enable,        // receiver enabled
    input  wire logic        tx_shift_ready,   // shifter can take a character
    input  wire logic        tx_busy,          // data/preamble/break in flight
    input  wire logic        tx_queue_evt,     // preamble or break queued
    input  wire rx_evt_t     rx_evt,           // receiver core events
    output logic             tx_load,          // pulse: shifter takes tx_word
    output logic      [8:0]  tx_word,          // ninth bit and data byte
    output irq_t             irq               // interrupt requests
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] rx_buf_q;
    logic [7:0] tx_buf_q;
    logic       rx_ninth_bit_q;
    logic       tx_ninth_bit_q;
    logic [3:0] err_en_q;          // overrun, noise, framing, parity
    logic       tx_holding_empty_q;
    logic       tx_complete_q;
    logic       tx_pending_q;
    logic       rx_full_q;
    logic       idle_q;
    logic       idle_armed_q;
    logic       overrun_flag_q;
    logic       noise_flag_q;
    logic       framing_flag_q;
    logic       parity_flag_q;
    logic       break_flag_q;
    logic       break_armed_q;
    logic       rx_active_flag_q;
    logic [7:0] seen_s1_q;         // status_one snapshot for clear sequence
    logic       seen_brk_q;
    logic       ack_q;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    logic req;
    logic rd_s1;
    logic rd_s2;
    logic rd_db;
    logic wr_db;
    logic wr_c3;
    logic xfer;
    logic rx_take;
    logic brk_take;
    assign req   = (read | write) & ~ack_q & clk_en;
    assign rd_s1 = req & read & hit(address, OFS_STATUS_ONE);
    assign rd_s2 = req & read & hit(address, OFS_STATUS_TWO);
    assign rd_db = req & read & hit(address, OFS_DATA_BUF);
    assign wr_db = req & write & hit(address, OFS_DATA_BUF) & byteenable[0];
    assign wr_c3 = req & write & hit(address, OFS_CTRL_THREE) & byteenable[0];
    // buffer to shifter handoff
    assign xfer  = clk_en & tx_pending_q & tx_shift_ready;
    // break also fills the buffer path; a plain char only when room
    assign brk_take = clk_en & rx_evt.brk & break_armed_q;
    assign rx_take  = clk_en & rx_evt.char_done & ~rx_full_q;

    // one wait cycle, answer on the second edge
    // wait kept as its own flop so the bus never sees a gate output
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ack_q       <= 1'b0;
            waitrequest <= 1'b1;
        end else if (clk_en) begin
            ack_q       <= (read | write) & ~ack_q;
            waitrequest <= ~((read | write) & ~ack_q);
        end
    end

    // status words
    logic [31:0] s1_word;
    logic [31:0] s2_word;
    logic [31:0] c3_word;
    always_comb begin
        s1_word = '0;
        s1_word[S1_THE] = tx_holding_empty_q;
        s1_word[S1_TC]  = tx_complete_q;
        s1_word[S1_RXF] = rx_full_q;
        s1_word[S1_IDL] = idle_q;
        s1_word[S1_OVR] = overrun_flag_q;
        s1_word[S1_NSE] = noise_flag_q;
        s1_word[S1_FRM] = framing_flag_q;
        s1_word[S1_PAR] = parity_flag_q;
        s2_word = '0;
        s2_word[S2_BRK] = break_flag_q;
        s2_word[S2_ACT] = rx_active_flag_q;
        c3_word = '0;
        c3_word[C3_RX9] = rx_ninth_bit_q;
        c3_word[C3_TX9] = tx_ninth_bit_q;
        c3_word[3:0]    = err_en_q;
    end

    // registered read data, stands from the answer edge
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            readdata <= RD_UNMAPPED;
        end else if (req & read) begin
            if (hit(address, OFS_STATUS_ONE)) readdata <= s1_word;
            else if (hit(address, OFS_STATUS_TWO)) readdata <= s2_word;
            else if (hit(address, OFS_DATA_BUF)) readdata <= {24'h00_0000, rx_buf_q};
            else if (hit(address, OFS_CTRL_THREE)) readdata <= c3_word;
            else readdata <= RD_UNMAPPED;
        end
    end

    // ------------------------------------------------------------
    // data buffers and ninth bits, no reset on purpose
    // ------------------------------------------------------------
    // reset must not disturb unread data
    always_ff @(posedge clk_sys) begin
        if (rx_take | brk_take) begin
            rx_buf_q <= brk_take ? 8'h00 : rx_evt.char_bits[7:0];
        end
        if (wr_db) begin
            tx_buf_q <= writedata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (brk_take) begin
            rx_ninth_bit_q <= 1'b0;
        end else if (rx_take) begin
            rx_ninth_bit_q <= char_len_sel ? rx_evt.char_bits[8]
                                           : rx_evt.char_bits[7];
        end
        if (wr_c3) begin
            tx_ninth_bit_q <= writedata[C3_TX9];
        end
    end

    // error enables
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            err_en_q <= RST_ERR_EN;
        end else if (wr_c3) begin
            err_en_q <= writedata[3:0];
        end
    end

    // ------------------------------------------------------------
    // transmit side
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_load <= 1'b0;
            tx_word <= 9'h000;
        end else if (clk_en) begin
            tx_load <= xfer;
            if (xfer) begin
                tx_word <= {char_len_sel & tx_ninth_bit_q, tx_buf_q};
            end
        end
    end

    // clear needs the flag seen set at the last status read
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_holding_empty_q <= RST_THE;
            tx_pending_q       <= 1'b0;
        end else if (clk_en) begin
            if (xfer) begin
                tx_holding_empty_q <= 1'b1;
                tx_pending_q       <= 1'b0;
            end else if (wr_db) begin
                tx_pending_q <= 1'b1;
                if (seen_s1_q[S1_THE]) tx_holding_empty_q <= 1'b0;
            end
        end
    end

    // queue clears it at once; the shifter may still lag 1.5 bit clocks
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_complete_q <= RST_TC;
        end else if (clk_en) begin
            if (wr_db | tx_queue_evt | tx_pending_q | tx_busy) begin
                tx_complete_q <= 1'b0;
            end else if (tx_holding_empty_q) begin
                tx_complete_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // clear-sequence snapshots
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            seen_s1_q  <= 8'h00;
            seen_brk_q <= 1'b0;
        end else begin
            if (rd_s1) seen_s1_q <= s1_word[7:0];
            else if (rd_db | wr_db) seen_s1_q <= 8'h00;
            if (rd_s2) seen_brk_q <= break_flag_q;
            else if (rd_db) seen_brk_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // receive flags; a set in the clearing cycle wins
    // ------------------------------------------------------------
    logic clr_rxf;
    logic clr_idl;
    logic clr_ovr;
    logic clr_nse;
    logic clr_frm;
    logic clr_par;
    assign clr_rxf = rd_db & seen_s1_q[S1_RXF];
    assign clr_idl = rd_db & seen_s1_q[S1_IDL];
    assign clr_ovr = rd_db & seen_s1_q[S1_OVR];
    assign clr_nse = rd_db & seen_s1_q[S1_NSE];
    assign clr_frm = rd_db & seen_s1_q[S1_FRM];
    assign clr_par = rd_db & seen_s1_q[S1_PAR];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_full_q      <= 1'b0;
            overrun_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (rx_take | brk_take) rx_full_q <= 1'b1;
            else if (clr_rxf) rx_full_q <= 1'b0;
            if (rx_evt.char_done & rx_full_q) overrun_flag_q <= 1'b1;
            else if (clr_ovr) overrun_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            noise_flag_q   <= 1'b0;
            framing_flag_q <= 1'b0;
            parity_flag_q  <= 1'b0;
        end else if (clk_en) begin
            if (rx_evt.noise) noise_flag_q <= 1'b1;
            else if (clr_nse) noise_flag_q <= 1'b0;
            if (rx_evt.frame_err | brk_take) framing_flag_q <= 1'b1;
            else if (clr_frm) framing_flag_q <= 1'b0;
            if (rx_evt.parity_err) parity_flag_q <= 1'b1;
            else if (clr_par) parity_flag_q <= 1'b0;
        end
    end

    // idle waits for a character after enable or after a clear
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            idle_q       <= 1'b0;
            idle_armed_q <= 1'b0;
        end else if (clk_en) begin
            if (rx_evt.idle_seen & idle_armed_q) idle_q <= 1'b1;
            else if (clr_idl) idle_q <= 1'b0;
            if (rx_take) idle_armed_q <= 1'b1;
            else if (clr_idl | ~rx_enable) idle_armed_q <= 1'b0;
        end
    end

    // break rearms only after ones on the line
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            break_flag_q  <= 1'b0;
            break_armed_q <= 1'b1;
        end else if (clk_en) begin
            if (brk_take) break_flag_q <= 1'b1;
            else if (rd_db & seen_brk_q) break_flag_q <= 1'b0;
            if (brk_take) break_armed_q <= 1'b0;
            else if (rx_evt.line_ones) break_armed_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_active_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (rx_evt.start_zero) rx_active_flag_q <= 1'b1;
            else if (rx_evt.false_start | rx_evt.idle_seen) rx_active_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // interrupt requests, registered
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq <= '0;
        end else if (clk_en) begin
            irq.tx  <= (tx_holding_empty_q & tx_empty_irq_en)
                     | (tx_complete_q & tx_done_irq_en);
            irq.rx  <= (rx_full_q & rx_full_irq_en) | (idle_q & idle_irq_en);
            irq.err <= (overrun_flag_q & err_en_q[C3_ORE])
                     | (noise_flag_q & err_en_q[C3_NEE])
                     | (framing_flag_q & err_en_q[C3_FEE])
                     | (parity_flag_q & err_en_q[C3_PEE]);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s1_read_seen_rxf;
        rd_s1 && rx_full_q;
    endsequence
    sequence buf_read;
        rd_db && seen_s1_q[S1_RXF];
    endsequence

    // the snapshot carries the sighting over any gap between the two reads that holds no data-buffer write,
    // so the clear step needs no long repetition to find its status read
    a_rxf_seen_snap: assert property (@(posedge clk_sys) disable iff (!nrst)
        s1_read_seen_rxf |=> seen_s1_q[S1_RXF])
        else $error("status sighting of rx_full lost");
    a_rxf_clear_seq: assert property (@(posedge clk_sys) disable iff (!nrst)
        (buf_read ##0 (!rx_take && !brk_take)) |=> !rx_full_q)
        else $error("rx_full not cleared by read sequence");
    a_wait_answer: assert property (@(posedge clk_sys) disable iff (!nrst)
        ((read || write) && !ack_q && clk_en) |=> !waitrequest)
        else $error("bus request not answered after one wait");
    a_ovr_hold_new: assert property (@(posedge clk_sys) disable iff (!nrst)
        (rd_db && !seen_s1_q[S1_OVR] && overrun_flag_q) |=> overrun_flag_q)
        else $error("overrun lost without status sighting");
    a_ovr_set_full: assert property (@(posedge clk_sys) disable iff (!nrst)
        (clk_en && rx_evt.char_done && rx_full_q && !brk_take) |=>
        (overrun_flag_q && rx_buf_q == $past(rx_buf_q)))
        else $error("overrun not flagged or buffer changed");
    a_ninth_cap: assert property (@(posedge clk_sys) disable iff (!nrst)
        (rx_take && !brk_take && char_len_sel) |=> rx_ninth_bit_q == $past(rx_evt.char_bits[8]))
        else $error("ninth bit not captured");
    a_ninth_copy: assert property (@(posedge clk_sys) disable iff (!nrst)
        (rx_take && !brk_take && !char_len_sel) |=> rx_ninth_bit_q == $past(rx_evt.char_bits[7]))
        else $error("ninth bit not copy of bit 7");
    a_tx_word_load: assert property (@(posedge clk_sys) disable iff (!nrst)
        xfer |=> (tx_load && tx_word[7:0] == $past(tx_buf_q)))
        else $error("shifter load wrong");
    a_the_set: assert property (@(posedge clk_sys) disable iff (!nrst)
        xfer |=> tx_holding_empty_q)
        else $error("holding empty not set");
    a_err_irq: assert property (@(posedge clk_sys) disable iff (!nrst)
        (clk_en && noise_flag_q && err_en_q[C3_NEE]) |=> irq.err)
        else $error("error request missing");
    a_brk_group: assert property (@(posedge clk_sys) disable iff (!nrst)
        brk_take |=> (break_flag_q && framing_flag_q && rx_full_q && !rx_ninth_bit_q))
        else $error("break side effects missing");
    a_idle_armed: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(idle_q) |-> $past(idle_armed_q))
        else $error("idle set without arming");
    // a queued preamble or break must drop completion at once
    a_tc_queue: assert property (@(posedge clk_sys) disable iff (!nrst)
        (clk_en && tx_queue_evt) |=> !tx_complete_q)
        else $error("completion still set after queueing");
endmodule
`default_nettype wire

// ### core/sci_flags_pkg.sv
// package: register map, field layout and carrier types for the serial status/buffer block
package sci_flags_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS_ONE = 8'h10;
    localparam logic [7:0] OFS_STATUS_TWO = 8'h14;
    localparam logic [7:0] OFS_DATA_BUF   = 8'h18;
    localparam logic [7:0] OFS_CTRL_THREE = 8'h1C;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int C3_RX9 = 7;
    localparam int C3_TX9 = 6;
    localparam int C3_ORE = 3;
    localparam int C3_NEE = 2;
    localparam int C3_FEE = 1;
    localparam int C3_PEE = 0;
    localparam int S1_THE = 7;
    localparam int S1_TC  = 6;
    localparam int S1_RXF = 5;
    localparam int S1_IDL = 4;
    localparam int S1_OVR = 3;
    localparam int S1_NSE = 2;
    localparam int S1_FRM = 1;
    localparam int S1_PAR = 0;
    localparam int S2_BRK = 1;
    localparam int S2_ACT = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] RST_ERR_EN = 4'h0;
    localparam logic       RST_THE    = 1'b1;
    localparam logic       RST_TC     = 1'b1;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // events from the receiver core, one-cycle pulses
    typedef struct packed {
        logic       char_done;
        logic [8:0] char_bits;
        logic       noise;
        logic       frame_err;
        logic       parity_err;
        logic       brk;
        logic       line_ones;
        logic       idle_seen;
        logic       start_zero;
        logic       false_start;
    } rx_evt_t;

    // interrupt request group
    typedef struct packed {
        logic tx;
        logic rx;
        logic err;
    } irq_t;
endpackage

// ### verif/sci_flags_tb_top.sv
// testbench: register-level tests of the serial status and buffer block
`timescale 1ns/1ps
`default_nettype none
module sci_flags_tb_top;
    import sci_flags_pkg::*;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0]  ien = 4'hF;
    logic        char_len_sel = 1'b1;
    logic        clk_en = 1'b1;
    logic        rx_enable = 1'b1;
    logic [3:0]  byteenable = 4'hF;
    logic [31:0] readdata;
    logic [31:0] rd;
    logic        waitrequest;
    logic        tx_load;
    logic        tx_shift_ready;
    logic        tx_busy;
    logic        tx_queue_evt;
    logic [8:0]  tx_word;
    rx_evt_t     rx_evt;
    irq_t        irq;
    int          err_total = 0;
    int          checks_done = 0;
    int          n;

    initial forever #12.5 clk_sys = ~clk_sys;

    sci_flags sci_flags_inst (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .char_len_sel(char_len_sel), .tx_empty_irq_en(ien[3]), .tx_done_irq_en(ien[2]),
        .rx_full_irq_en(ien[1]), .idle_irq_en(ien[0]), .rx_enable(rx_enable),
        .tx_shift_ready(tx_shift_ready), .tx_busy(tx_busy), .tx_queue_evt(tx_queue_evt),
        .rx_evt(rx_evt), .tx_load(tx_load), .tx_word(tx_word), .irq(irq));

    sci_remote_model sci_remote_model_inst (.clk_sys(clk_sys), .nrst(nrst),
        .tx_load(tx_load), .tx_word(tx_word), .tx_shift_ready(tx_shift_ready),
        .tx_busy(tx_busy), .tx_queue_evt(tx_queue_evt), .rx_evt(rx_evt));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    // avalon access: hold until waitrequest sampled low, then release
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clk_sys);
        address   <= a;
        writedata <= wd;
        read      <= !we;
        write     <= we;
        do begin
            @(posedge clk_sys);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        if (k >= 50)
            chk("waitrequest", 32'h0, 32'h1);
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), e, rd & m);
    endtask

    // watchdog: whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        rc(OFS_STATUS_ONE, 32'hFF, 32'hC0);
        rc(OFS_STATUS_TWO, 32'hFF, 32'h00);
        rc(OFS_CTRL_THREE, 32'h0F, 32'h00);
        rc(8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
        bus(1'b1, OFS_CTRL_THREE, 32'h0000_004F);
        rc(OFS_CTRL_THREE, 32'h7F, 32'h4F);
        // transmit with the shifter stalled, so the pending state is visible
        sci_remote_model_inst.hold <= 1'b1;
        rc(OFS_STATUS_ONE, 32'hFF, 32'hC0);
        bus(1'b1, OFS_DATA_BUF, 32'h0000_00A5);
        rc(OFS_STATUS_ONE, 32'hFF, 32'h00);
        chk("irq", 32'h0, {29'h0, irq});
        n = sci_remote_model_inst.loads;
        sci_remote_model_inst.hold <= 1'b0;
        for (int k = 0; k < 100 && sci_remote_model_inst.loads == n; k++)
            @(posedge clk_sys);
        chk("tx word", 32'h1A5, {23'h0, sci_remote_model_inst.last_word});
        rc(OFS_STATUS_ONE, 32'hFF, 32'h80);
        chk("irq", 32'h4, {29'h0, irq});
        for (int k = 0; k < 100 && tx_busy; k++)
            @(posedge clk_sys);
        rc(OFS_STATUS_ONE, 32'hFF, 32'hC0);
        // a queued preamble clears completion while it is sent
        sci_remote_model_inst.queue_one();
        rc(OFS_STATUS_ONE, 32'hFF, 32'h80);
        for (int k = 0; k < 100 && tx_busy; k++)
            @(posedge clk_sys);
        // receive: idle not armed before a character
        sci_remote_model_inst.ev(18'h0_0004);
        rc(OFS_STATUS_ONE, 32'hFF, 32'hC0);
        sci_remote_model_inst.ev({1'b1, 9'h15A, 8'h00});
        rc(OFS_STATUS_ONE, 32'hFF, 32'hE0);
        rc(OFS_CTRL_THREE, 32'h80, 32'h80);
        chk("irq", 32'h6, {29'h0, irq});
        sci_remote_model_inst.ev(18'h0_0004);
        rc(OFS_STATUS_ONE, 32'hFF, 32'hF0);
        sci_remote_model_inst.ev({1'b1, 9'h033, 8'h00});
        rc(OFS_STATUS_ONE, 32'hFF, 32'hF8);
        rc(OFS_DATA_BUF, 32'hFF, 32'h5A);
        rc(OFS_STATUS_ONE, 32'hFF, 32'hC0);
        // overrun between the two reads survives the clear
        sci_remote_model_inst.ev({1'b1, 9'h011, 8'h00});
        rc(OFS_STATUS_ONE, 32'hFF, 32'hE0);
        sci_remote_model_inst.ev({1'b1, 9'h022, 8'h00});
        rc(OFS_DATA_BUF, 32'hFF, 32'h11);
        rc(OFS_STATUS_ONE, 32'hFF, 32'hC8);
        rc(OFS_DATA_BUF, 32'hFF, 32'h11);
        rc(OFS_STATUS_ONE, 32'hFF, 32'hC0);
        // 8-bit mode: ninth bit copies data bit 7
        char_len_sel <= 1'b0;
        sci_remote_model_inst.ev({1'b1, 9'h080, 8'h00});
        rc(OFS_CTRL_THREE, 32'h80, 32'h80);
        rc(OFS_STATUS_ONE, 32'hFF, 32'hE0);
        rc(OFS_DATA_BUF, 32'hFF, 32'h80);
        // mid-run reset keeps buffer and ninth bits, clears enables
        nrst <= 1'b0;
        @(posedge clk_sys);
        nrst <= 1'b1;
        rc(OFS_CTRL_THREE, 32'hFF, 32'hC0);
        rc(OFS_DATA_BUF, 32'hFF, 32'h80);
        bus(1'b1, OFS_CTRL_THREE, 32'h0000_004F);
        // all three receive errors at once
        sci_remote_model_inst.ev({1'b1, 9'h055, 8'hE0});
        rc(OFS_STATUS_ONE, 32'hFF, 32'hE7);
        chk("irq", 32'h7, {29'h0, irq});
        ien <= 4'h0;
        repeat (3) @(posedge clk_sys);
        chk("irq", 32'h1, {29'h0, irq});
        bus(1'b1, OFS_CTRL_THREE, 32'h0000_0040);
        rc(OFS_STATUS_ONE, 32'hFF, 32'hE7);
        chk("irq", 32'h0, {29'h0, irq});
        bus(1'b1, OFS_CTRL_THREE, 32'h0000_004F);
        ien <= 4'hF;
        rc(OFS_DATA_BUF, 32'hFF, 32'h55);
        rc(OFS_STATUS_ONE, 32'hFF, 32'hC0);
        chk("irq", 32'h4, {29'h0, irq});
        // break in 9-bit mode
        char_len_sel <= 1'b1;
        sci_remote_model_inst.ev(18'h0_0010);
        rc(OFS_STATUS_TWO, 32'hFF, 32'h02);
        rc(OFS_STATUS_ONE, 32'hFF, 32'hE2);
        rc(OFS_CTRL_THREE, 32'h80, 32'h00);
        rc(OFS_DATA_BUF, 32'hFF, 32'h00);
        rc(OFS_STATUS_TWO, 32'hFF, 32'h00);
        rc(OFS_STATUS_ONE, 32'hFF, 32'hC0);
        // reception in progress: start zero, then false start
        sci_remote_model_inst.ev(18'h0_0002);
        rc(OFS_STATUS_TWO, 32'hFF, 32'h01);
        sci_remote_model_inst.ev(18'h0_0001);
        rc(OFS_STATUS_TWO, 32'hFF, 32'h00);
        // frozen clock enable: a character posted meanwhile is lost
        clk_en <= 1'b0;
        sci_remote_model_inst.ev({1'b1, 9'h0C3, 8'h00});
        clk_en <= 1'b1;
        rc(OFS_STATUS_ONE, 32'hFF, 32'hC0);
        // receiver disable after a character disarms idle again
        sci_remote_model_inst.ev({1'b1, 9'h0C3, 8'h00});
        rx_enable <= 1'b0;
        @(posedge clk_sys);
        rx_enable <= 1'b1;
        sci_remote_model_inst.ev(18'h0_0004);
        rc(OFS_STATUS_ONE, 32'hFF, 32'hE0);
        rc(OFS_DATA_BUF, 32'hFF, 32'hC3);
        // control write with lane 0 off is ignored
        byteenable <= 4'hE;
        bus(1'b1, OFS_CTRL_THREE, 32'h0000_0000);
        byteenable <= 4'hF;
        rc(OFS_CTRL_THREE, 32'h7F, 32'h4F);
        report_and_stop();
    end
endmodule
`default_nettype wire

// ### verif/sci_remote_model.sv
// far-side model: shifter that takes loaded words, receiver core that posts events
`timescale 1ns/1ps
`default_nettype none
module sci_remote_model
    import sci_flags_pkg::*;
(
    input  wire logic       clk_sys,        // bus clock
    input  wire logic       nrst,           // async reset, active low
    input  wire logic       tx_load,        // shifter load pulse
    input  wire logic [8:0] tx_word,        // ninth bit and byte
    output logic            tx_shift_ready, // shifter free
    output logic            tx_busy,        // word in flight
    output logic            tx_queue_evt,   // preamble or break queued
    output var rx_evt_t     rx_evt          // receiver events
);
    logic       hold = 1'b0;
    logic       queue_req = 1'b0;
    logic [8:0] last_word;
    int         loads = 0;
    int         busy_cnt = 0;

    // ------------------------------------------------------------
    // shifter: busy 20 cycles per word or queued preamble, stallable
    // ------------------------------------------------------------
    assign tx_shift_ready = !hold && busy_cnt == 0;
    assign tx_busy        = busy_cnt != 0;
    assign tx_queue_evt   = queue_req;

    // load count kept over reset so the bench can wait on it
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            busy_cnt <= 0;
        end else if (tx_load || queue_req) begin
            busy_cnt <= 20;
            if (tx_load) begin
                last_word <= tx_word;
                loads     <= loads + 1;
            end
        end else if (busy_cnt != 0) begin
            busy_cnt <= busy_cnt - 1;
        end
    end

    // one-cycle event pulse from the receiver core
    task automatic ev(input logic [17:0] v);
        @(posedge clk_sys);
        rx_evt <= v;
        @(posedge clk_sys);
        rx_evt <= '0;
    endtask

    // one-cycle preamble or break queue pulse
    task automatic queue_one;
        @(posedge clk_sys);
        queue_req <= 1'b1;
        @(posedge clk_sys);
        queue_req <= 1'b0;
    endtask

    initial rx_evt = '0;
endmodule
`default_nettype wire
